// ==== rtl/prs_pkg.sv ====
// package for the power-on reset sequencer: timing constants and state carrier
// assumes a single 250 MHz clock domain
`default_nettype none
package prs_pkg;
    // ========================================
    // timing
    localparam int unsigned PRS_CLK_MHZ = 250;
    localparam int unsigned PRS_DELAY_MS = 18;
    localparam int unsigned PRS_DELAY_CYC = PRS_DELAY_MS * 1000 * PRS_CLK_MHZ;
    localparam int unsigned PRS_CNT_W = 23;
    // ========================================
    // sequencer states
    typedef enum logic [2:0] {
        PRS_HOLD = 3'b001,
        PRS_COUNT = 3'b010,
        PRS_RUN = 3'b100
    } prs_state_t;
    // ========================================
    // full state of the sequencer
    typedef struct packed {
        prs_state_t state;
        logic latch;
        logic timing;
        logic [PRS_CNT_W-1:0] count;
    } prs_regs_t;
endpackage : prs_pkg
`default_nettype wire

// ==== rtl/prs_delay_timer.sv ====
// reset-delay timer: counts while enabled, cleared otherwise, flags expiry
// assumes synchronous active-high reset and a freezing clock enable
`default_nettype none
module prs_delay_timer
    import prs_pkg::*;
#(
    parameter int unsigned CNT_W = PRS_CNT_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // control
    input wire logic run_in,
    input wire logic [CNT_W-1:0] limit_in,
    // status
    output logic done_out
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic done_q;
    logic done_d;

    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (!run_in) begin
            cnt_d = '0;
        end else if (cnt_q >= limit_in - CNT_W'(1)) begin
            done_d = 1'b1;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (clk_en_in) begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_out = done_q;
endmodule : prs_delay_timer
`default_nettype wire

// ==== rtl/prs_sequencer.sv ====
// power-on reset sequencer: reset latch released after the delay once master clear is high
// assumes power-up is presented as sys_rst_in and master clear is synchronous to clk_in
`default_nettype none
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int unsigned DELAY_CYC = PRS_DELAY_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // board side
    input wire logic master_clear_input_in,
    // chip side
    output logic chip_rst_out,
    output logic timing_out
);
    prs_regs_t r_q;
    prs_regs_t r_d;
    logic timer_done;
    logic timer_run;
    // expiry count at the timer's width
    localparam logic [PRS_CNT_W-1:0] DELAY_LIM = PRS_CNT_W'(DELAY_CYC);

    // ========================================
    // reset-delay timer
    assign timer_run = (r_q.state == PRS_COUNT) && master_clear_input_in;

    prs_delay_timer #(
        .CNT_W(PRS_CNT_W)
    ) u_reset_delay_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .run_in(timer_run),
        .limit_in(DELAY_LIM),
        .done_out(timer_done)
    );

    // ========================================
    // sequencer
    always_comb begin
        r_d = r_q;
        // shadow count of enabled counting cycles, read only by the checks
        r_d.count = '0;
        if (timer_run && !timer_done) begin
            r_d.count = r_q.count + PRS_CNT_W'(1);
        end
        unique case (r_q.state)
            PRS_HOLD: begin
                r_d.latch = 1'b1;
                if (master_clear_input_in) begin
                    r_d.state = PRS_COUNT;
                end
            end
            PRS_COUNT: begin
                if (!master_clear_input_in) begin
                    r_d.state = PRS_HOLD;
                    r_d.latch = 1'b1;
                end else if (timer_done) begin
                    r_d.state = PRS_RUN;
                    r_d.latch = 1'b0;
                end
            end
            PRS_RUN: begin
                // no supply monitor here, only master clear low or sys_rst_in restarts
                if (!master_clear_input_in) begin
                    r_d.state = PRS_HOLD;
                    r_d.latch = 1'b1;
                end
            end
            default: begin
                r_d.state = PRS_HOLD;
                r_d.latch = 1'b1;
            end
        endcase
        // counting flag kept in its own flop so the output is registered
        r_d.timing = (r_d.state == PRS_COUNT);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r_q.state <= PRS_HOLD;
            r_q.latch <= 1'b1;
            r_q.timing <= 1'b0;
            r_q.count <= '0;
        end else if (clk_en_in) begin
            r_q <= r_d;
        end
    end

    assign chip_rst_out = r_q.latch;
    assign timing_out = r_q.timing;

    // ========================================
    // checks
    logic past_valid_q;
    always_ff @(posedge clk_in) begin
        past_valid_q <= !sys_rst_in;
    end

    a_latch_at_powerup: assert property (@(posedge clk_in)
        sys_rst_in |=> (chip_rst_out && !timing_out && (r_q.count == '0) && !timer_done))
        else $error("latch not set after power-up");
    a_idle_when_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && !master_clear_input_in) |=> !timer_done)
        else $error("timer expired while idle");
    a_release_on_done: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && timer_done && r_q.state == PRS_COUNT && master_clear_input_in)
            |=> !chip_rst_out)
        else $error("reset not released at time-out");
    a_no_release_early: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (chip_rst_out && !timer_done) |=> chip_rst_out)
        else $error("reset released before time-out");
    a_stay_released: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!chip_rst_out && master_clear_input_in) |=> !chip_rst_out)
        else $error("reset without cause");
    a_clear_holds_rst: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (past_valid_q && clk_en_in && !master_clear_input_in) |=> chip_rst_out && !timing_out)
        else $error("reset not held while master clear low");
    a_count_starts: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && r_q.state == PRS_HOLD && master_clear_input_in) |=> timing_out)
        else $error("timer did not start on master clear high");
    a_freeze: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !clk_en_in |=> ($stable(r_q) && $stable(timer_done)))
        else $error("state changed while clock enable low");

    // ========================================
    // checks: delay timer against the shadow count
    a_no_done_early: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (timer_run && (r_q.count < DELAY_LIM))
            |-> !timer_done)
        else $error("timer expired before the delay count");

    a_done_on_time: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (timer_run && (r_q.count == DELAY_LIM))
            |-> timer_done)
        else $error("timer missed the delay count");

    a_count_bounded: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (r_q.count <= DELAY_LIM))
        else $error("delay count ran past the time-out");

    a_count_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (r_q.state != PRS_COUNT)
            |-> (r_q.count == '0))
        else $error("delay count moved outside counting");

    a_timer_restart: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && !master_clear_input_in)
            |=> ((r_q.count == '0) && !timer_done))
        else $error("timer not cleared while master clear low");

    a_keeps_counting: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && timer_run && !timer_done)
            |=> timing_out)
        else $error("counting stopped before the time-out");

    // ========================================
    // checks: cause of every edge on the outputs
    a_rst_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(chip_rst_out)
            |-> (!$past(master_clear_input_in) || $past(sys_rst_in)))
        else $error("internal reset rose without a cause");

    a_release_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(chip_rst_out)
            |-> $past(timer_done))
        else $error("internal reset fell without a time-out");

    a_timing_rise: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(timing_out)
            |-> $past(master_clear_input_in))
        else $error("counting began with master clear low");

    a_timing_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(timing_out)
            |-> ($past(timer_done) || !$past(master_clear_input_in) || $past(sys_rst_in)))
        else $error("counting stopped without a cause");

    // ========================================
    // checks: state and outputs agree
    a_state_onehot: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $onehot(r_q.state))
        else $error("sequencer state not one-hot");

    a_timing_state: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (timing_out == (r_q.state == PRS_COUNT)))
        else $error("counting flag disagrees with state");

    a_run_released: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (r_q.state == PRS_RUN)
            |-> (!chip_rst_out && !timing_out))
        else $error("reset or counting shown while running");

    a_held_until_run: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (r_q.state != PRS_RUN)
            |-> chip_rst_out)
        else $error("reset dropped before running");

    a_hold_waits: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && (r_q.state == PRS_HOLD) && !master_clear_input_in)
            |=> (r_q.state == PRS_HOLD))
        else $error("left hold with master clear low");

    a_hold_no_done: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        timer_done |-> (r_q.state != PRS_HOLD))
        else $error("timer expiry seen in hold");

    a_clear_aborts: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (clk_en_in && (r_q.state == PRS_COUNT) && !master_clear_input_in)
            |=> (r_q.state == PRS_HOLD))
        else $error("count not aborted on master clear low");
endmodule : prs_sequencer
`default_nettype wire

// ==== tb/prs_board_model.sv ====
// board model: supply settling and master clear network
// assumes the bench drives its inputs at the falling clock edge
`default_nettype none
module prs_board_model (
    // board state
    input wire logic supply_ok_in,
    input wire logic release_in,
    // device pin
    output logic master_clear_out
);
    // ========================================
    // master clear held low until the supply is stable
    assign master_clear_out = supply_ok_in & release_in;
endmodule : prs_board_model
`default_nettype wire

// ==== tb/tb_prs_sequencer.sv ====
// bench for the power-on reset sequencer with a short delay count
// assumes prs_board_model sits on the master clear pin
`default_nettype none
module tb_prs_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DLY = 8;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic supply_ok = 1'b0;
    logic rel = 1'b0;
    logic master_clear_input;
    logic chip_rst_out;
    logic timing_out;
    int n_fail = 0;
    int tests_run = 0;
    prs_board_model brd_u (.supply_ok_in(supply_ok), .release_in(rel), .master_clear_out(master_clear_input));
    prs_sequencer #(.DELAY_CYC(DLY)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .master_clear_input_in(master_clear_input),
        .chip_rst_out(chip_rst_out), .timing_out(timing_out));
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask : step
    task automatic chk(input logic r, input logic t, input string m);
        tests_run++;
        if (chip_rst_out !== r || timing_out !== t) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    // ========================================
    // scenarios
    task automatic expect_count();
        step(2);
        chk(1'b1, 1'b1, "counting");
        step(DLY - 1);
        chk(1'b1, 1'b1, "early release");
        step(1);
        chk(1'b0, 1'b0, "late release");
    endtask : expect_count
    task automatic s_hold();
        chk(1'b1, 1'b0, "power-up state");
        sys_rst_in = 1'b0;
        supply_ok = 1'b1;
        step(20);
        chk(1'b1, 1'b0, "idle while clear low");
    endtask : s_hold
    task automatic s_count();
        rel = 1'b1;
        expect_count();
        step(20);
        chk(1'b0, 1'b0, "reset came back");
    endtask : s_count
    task automatic s_restart();
        rel = 1'b0;
        step(2);
        chk(1'b1, 1'b0, "clear low");
        rel = 1'b1;
        step(6);
        rel = 1'b0;
        step(2);
        chk(1'b1, 1'b0, "abort");
        rel = 1'b1;
        expect_count();
    endtask : s_restart
    task automatic s_freeze();
        rel = 1'b0;
        step(2);
        rel = 1'b1;
        step(3);
        clk_en_in = 1'b0;
        step(4);
        chk(1'b1, 1'b1, "frozen");
        clk_en_in = 1'b1;
        step(DLY - 2);
        chk(1'b1, 1'b1, "early after freeze");
        step(1);
        chk(1'b0, 1'b0, "late after freeze");
    endtask : s_freeze
    task automatic s_rerun();
        sys_rst_in = 1'b1;
        step(1);
        chk(1'b1, 1'b0, "second reset");
        sys_rst_in = 1'b0;
        expect_count();
    endtask : s_rerun
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        #4000;
        n_fail++;
        conclude();
    end
    initial begin
        step(3);
        s_hold();
        s_count();
        s_restart();
        s_freeze();
        s_rerun();
        conclude();
    end
endmodule : tb_prs_sequencer
`default_nettype wire
